/* File: design/address_matcher.sv */
// compares a shifted byte against the own address register
// assumes: inputs are stable flops on ref_clk; output is combinational
`timescale 1ns/10ps
`default_nettype none

module address_matcher
(
  // byte and address
  input  wire logic [7:0] shift_byte,
  input  wire logic [7:0] own_addr,
  // match results
  output logic            high_match,
  output logic            low_match
);

  // compares the upper seven bits, or all eight
  function automatic logic bits_equal(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       full);
    bits_equal = (a[7:1] == b[7:1]) && (!full || (a[0] == b[0]));
  endfunction : bits_equal

  // shift bits 7..1 for first bytes, whole byte for the low byte
  assign high_match = bits_equal(shift_byte, own_addr, 1'b0);
  assign low_match  = bits_equal(shift_byte, own_addr, 1'b1);

endmodule : address_matcher

`default_nettype wire

/* File: design/bus_sampler.sv */
// synchronises the two bus pins and finds clock edges, start and stop
// assumes: pins are asynchronous to ref_clk and far slower than it
`timescale 1ns/10ps
`default_nettype none

module bus_sampler
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // raw pin levels
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  // sampled levels and events
  output logic      scl_s,
  output logic      sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);

  logic [1:0] scl_meta_reg;
  logic [1:0] sda_meta_reg;
  logic       scl_old_reg;
  logic       sda_old_reg;
  logic [1:0] scl_meta_next;
  logic [1:0] sda_meta_next;

  // ****************************************
  // two-stage synchronisers, idle level high
  // ****************************************
  always_comb
  begin
    scl_meta_next = {scl_meta_reg[0], scl_pin};
    sda_meta_next = {sda_meta_reg[0], sda_pin};
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      scl_meta_reg <= 2'h3;
      sda_meta_reg <= 2'h3;
      scl_old_reg  <= 1'b1;
      sda_old_reg  <= 1'b1;
    end
    else
    begin
      scl_meta_reg <= scl_meta_next;
      sda_meta_reg <= sda_meta_next;
      scl_old_reg  <= scl_meta_reg[1];
      sda_old_reg  <= sda_meta_reg[1];
    end
  end

  // edge and condition decode from the second stage only
  assign scl_s     = scl_meta_reg[1];
  assign sda_s     = sda_meta_reg[1];
  assign scl_rise  = scl_meta_reg[1] & ~scl_old_reg;
  assign scl_fall  = ~scl_meta_reg[1] & scl_old_reg;
  assign start_det = scl_meta_reg[1] & scl_old_reg &
                     ~sda_meta_reg[1] & sda_old_reg;
  assign stop_det  = scl_meta_reg[1] & scl_old_reg &
                     sda_meta_reg[1] & ~sda_old_reg;

endmodule : bus_sampler

`default_nettype wire

/* File: design/two_wire_slave_port.sv */
// two-wire serial slave port with firmware master support
// assumes: pins resolved open-drain outside; software ports on ref_clk
//
// Functional notes
// - acknowledge every accepted received byte
// - release data after master withholds acknowledge
// - hold clock low to delay next byte
// - stretch on transmit; on receive if release clear
// - lost arbitration turns off firmware data drive
// - slave keeps receiving after lost arbitration
// - held clock low period, wait for rise
// - act only after the clock line rises
// - seven and ten bit address, start stop flags
// - run only when enabled; mode field selects
// - open-drain pins, override when slave drives
// - status is read-only view of state
// - full byte copied to buffer, flag raised
// - byte while full sets overflow, discarded
// - accepted byte buffered and acknowledged at the same eighth fall
// - full or overflow: no ack, flag still set
// - buffer read clears full; overflow software cleared
// - sample on rise, match on eighth fall
// - shift transmit bits on falling clock edges
// - firmware master mode keeps slave idle
`timescale 1ns/10ps
`default_nettype none
`include "two_wire_map.svh"

module two_wire_slave_port
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // bus pins, oe low means pulled low
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // firmware pin direction, 0 drives low (bit1 data, bit0 clock)
  input  wire logic [1:0] pin_direction_bits,
  // control byte
  input  wire logic       ctrl_we,
  input  wire logic [7:0] ctrl_wdata,
  output logic      [7:0] serial_port_control,
  // status byte
  output logic      [7:0] serial_port_status,
  // transfer buffer
  input  wire logic       buf_we,
  input  wire logic [7:0] buf_wdata,
  input  wire logic       buf_re,
  output logic      [7:0] transfer_buffer,
  // own address
  input  wire logic       addr_we,
  input  wire logic [7:0] addr_wdata,
  output logic      [7:0] own_address_register,
  // flags
  input  wire logic       flag_clr,
  output logic            port_interrupt_flag,
  output logic            arb_lost
);

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic high_match, low_match;

  two_wire_pkg::slave_state_e state_reg, state_next;
  two_wire_pkg::addr_phase_e  phase_reg, phase_next;
  logic [7:0] shift_reg, shift_next, buf_reg, buf_next;
  logic [7:0] ctl_reg, ctl_next, own_reg, own_next;
  logic [3:0] cnt_reg, cnt_next;
  logic       bf_reg, bf_next, irq_reg, irq_next, ua_reg, ua_next;
  logic       st_reg, st_next, sp_reg, sp_next, rd_reg, rd_next;
  logic       da_reg, da_next, hold_reg, hold_next, ackd_reg, ackd_next;
  logic       ten_reg, ten_next, mack_reg, mack_next;
  logic       own_fw_reg, own_fw_next, lost_reg, lost_next;
  logic       en, ten_mode, sp_int, slave_on, match, accept, byte_end;
  logic       slave_sda_low, fw_sda, fw_scl;

  // ****************************************
  // submodules
  // ****************************************
  bus_sampler u_sampler
  (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .scl_pin   (scl_in),
    .sda_pin   (sda_in),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  address_matcher u_matcher
  (
    .shift_byte (shift_reg),
    .own_addr   (own_reg),
    .high_match (high_match),
    .low_match  (low_match)
  );

  // ****************************************
  // mode decode
  // ****************************************
  always_comb
  begin
    en       = ctl_reg[`CTL_EN_BIT];
    ten_mode = (ctl_reg[3:0] == `MODE_SLV10) ||
               (ctl_reg[3:0] == `MODE_SLV10_SP);
    sp_int   = (ctl_reg[3:0] == `MODE_SLV7_SP) ||
               (ctl_reg[3:0] == `MODE_SLV10_SP) ||
               (ctl_reg[3:0] == `MODE_FW_MST);
    slave_on = en && (ctl_reg[3:0] == `MODE_SLV7 || ten_mode ||
               ctl_reg[3:0] == `MODE_SLV7_SP);
  end

  // address or data byte acceptance at the eighth fall
  always_comb
  begin
    byte_end = (state_reg == two_wire_pkg::ST_RECV) && scl_fall &&
               (cnt_reg == `BYTE_LAST_BIT);
    case (phase_reg)
      two_wire_pkg::PH_HIGH:
        match = high_match && (!ten_mode || ten_reg || !shift_reg[0]);
      two_wire_pkg::PH_LOW:  match = low_match;
      default:               match = 1'b1;
    endcase
    accept = match && !bf_reg && !ctl_reg[`CTL_OVF_BIT];
  end

  // ****************************************
  // slave sequencer and software registers
  // ****************************************
  always_comb
  begin
    state_next  = state_reg;
    phase_next  = phase_reg;
    shift_next  = shift_reg;
    buf_next    = buf_reg;
    ctl_next    = ctl_reg;
    own_next    = own_reg;
    cnt_next    = cnt_reg;
    bf_next     = bf_reg;
    irq_next    = irq_reg;
    ua_next     = ua_reg;
    st_next     = st_reg;
    sp_next     = sp_reg;
    rd_next     = rd_reg;
    da_next     = da_reg;
    hold_next   = hold_reg;
    ackd_next   = ackd_reg;
    ten_next    = ten_reg;
    mack_next   = mack_reg;
    own_fw_next = own_fw_reg;
    lost_next   = lost_reg;
    // software side; hardware sets below win over these clears
    if (ctrl_we)
      ctl_next = ctrl_wdata;
    if (flag_clr)
      irq_next = 1'b0;
    if (buf_re)
      bf_next = 1'b0;
    if (addr_we)
    begin
      own_next = addr_wdata;
      ua_next  = 1'b0;
    end
    if (buf_we)
    begin
      buf_next = buf_wdata;
      if (state_reg != two_wire_pkg::ST_RECV)
        shift_next = buf_wdata;
    end
    // firmware master ownership and arbitration watch
    if (en && !pin_direction_bits[0])
      own_fw_next = 1'b1;
    if (scl_rise && own_fw_reg && pin_direction_bits[1] &&
        !slave_sda_low && !sda_s)
      lost_next = 1'b1;
    // clock stretch release once software is ready
    if (hold_reg && ctl_next[`CTL_REL_BIT] && !ua_next)
      hold_next = 1'b0;
    // bus sequencing
    if (!en)
    begin
      state_next  = two_wire_pkg::ST_IDLE;
      st_next     = 1'b0;
      sp_next     = 1'b0;
      hold_next   = 1'b0;
      ackd_next   = 1'b0;
      rd_next     = 1'b0;
      own_fw_next = 1'b0;
      lost_next   = 1'b0;
    end
    else if (stop_det)
    begin
      state_next  = two_wire_pkg::ST_IDLE;
      sp_next     = 1'b1;
      st_next     = 1'b0;
      ten_next    = 1'b0;
      hold_next   = 1'b0;
      ackd_next   = 1'b0;
      own_fw_next = 1'b0;
      lost_next   = 1'b0;
      if (sp_int)
        irq_next = 1'b1;
    end
    else if (start_det)
    begin
      st_next    = 1'b1;
      sp_next    = 1'b0;
      ackd_next  = 1'b0;
      hold_next  = 1'b0;
      phase_next = two_wire_pkg::PH_HIGH;
      cnt_next   = 4'h0;
      if (sp_int)
        irq_next = 1'b1;
      if (slave_on)
        state_next = two_wire_pkg::ST_RECV;
    end
    else
    begin
      case (state_reg)
        two_wire_pkg::ST_RECV:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 4'h1;
          end
          if (byte_end && !match)
            state_next = two_wire_pkg::ST_IDLE;
          else if (byte_end)
          begin
            state_next = two_wire_pkg::ST_ACK;
            da_next    = (phase_reg == two_wire_pkg::PH_DATA);
            if (accept)
            begin
              buf_next  = shift_reg;
              bf_next   = 1'b1;
              ackd_next = 1'b1;
            end
            else if (bf_reg)
              ctl_next[`CTL_OVF_BIT] = 1'b1;
            if (accept && phase_reg == two_wire_pkg::PH_HIGH)
            begin
              rd_next = shift_reg[0];
              if (ten_mode && !ten_reg)
              begin
                ua_next    = 1'b1;
                phase_next = two_wire_pkg::PH_LOW;
              end
              else
                phase_next = two_wire_pkg::PH_DATA;
            end
            else if (accept && phase_reg == two_wire_pkg::PH_LOW)
            begin
              ua_next    = 1'b1;
              ten_next   = 1'b1;
              phase_next = two_wire_pkg::PH_DATA;
            end
          end
        end
        two_wire_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            ackd_next = 1'b0;
            irq_next  = 1'b1;
            cnt_next  = 4'h0;
            if (!ackd_reg)
              state_next = two_wire_pkg::ST_IDLE;
            else if (rd_reg && phase_reg == two_wire_pkg::PH_DATA)
            begin
              state_next              = two_wire_pkg::ST_SEND;
              ctl_next[`CTL_REL_BIT]  = 1'b0;
              hold_next               = 1'b1;
            end
            else
            begin
              state_next = two_wire_pkg::ST_RECV;
              hold_next  = ua_next || !ctl_next[`CTL_REL_BIT];
            end
          end
        end
        two_wire_pkg::ST_SEND:
        begin
          if (scl_fall && !hold_reg)
          begin
            if (cnt_reg == 4'h7)
              state_next = two_wire_pkg::ST_SACK;
            else
            begin
              shift_next = {shift_reg[6:0], 1'b0};
              cnt_next   = cnt_reg + 4'h1;
            end
          end
        end
        two_wire_pkg::ST_SACK:
        begin
          if (scl_rise)
            mack_next = !sda_s;
          if (scl_fall)
          begin
            irq_next = 1'b1;
            cnt_next = 4'h0;
            if (mack_reg)
            begin
              state_next             = two_wire_pkg::ST_SEND;
              ctl_next[`CTL_REL_BIT] = 1'b0;
              hold_next              = 1'b1;
            end
            else
            begin
              state_next = two_wire_pkg::ST_IDLE;
              rd_next    = 1'b0;
              da_next    = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_reg  <= two_wire_pkg::ST_IDLE;
      phase_reg  <= two_wire_pkg::PH_HIGH;
      shift_reg  <= 8'h00;
      buf_reg    <= 8'h00;
      ctl_reg    <= `CTL_RESET;
      own_reg    <= `OWN_ADDR_RST;
      cnt_reg    <= 4'h0;
      bf_reg     <= 1'b0;
      irq_reg    <= 1'b0;
      ua_reg     <= 1'b0;
      st_reg     <= 1'b0;
      sp_reg     <= 1'b0;
      rd_reg     <= 1'b0;
      da_reg     <= 1'b0;
      hold_reg   <= 1'b0;
      ackd_reg   <= 1'b0;
      ten_reg    <= 1'b0;
      mack_reg   <= 1'b0;
      own_fw_reg <= 1'b0;
      lost_reg   <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      phase_reg  <= phase_next;
      shift_reg  <= shift_next;
      buf_reg    <= buf_next;
      ctl_reg    <= ctl_next;
      own_reg    <= own_next;
      cnt_reg    <= cnt_next;
      bf_reg     <= bf_next;
      irq_reg    <= irq_next;
      ua_reg     <= ua_next;
      st_reg     <= st_next;
      sp_reg     <= sp_next;
      rd_reg     <= rd_next;
      da_reg     <= da_next;
      hold_reg   <= hold_next;
      ackd_reg   <= ackd_next;
      ten_reg    <= ten_next;
      mack_reg   <= mack_next;
      own_fw_reg <= own_fw_next;
      lost_reg   <= lost_next;
    end
  end

  // ****************************************
  // open-drain pin drive and read-back
  // ****************************************
  always_comb
  begin
    slave_sda_low = ackd_reg || (state_reg == two_wire_pkg::ST_SEND &&
                    !shift_reg[7]);
    fw_sda        = !pin_direction_bits[1] && !lost_reg;
    fw_scl        = !pin_direction_bits[0];
  end

  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = !(en && (hold_reg || fw_scl));
  assign sda_oe_n = !(en && (slave_sda_low || fw_sda));
  assign serial_port_control  = ctl_reg;
  assign serial_port_status   = {2'b00, da_reg, sp_reg, st_reg, rd_reg,
                                 ua_reg, bf_reg};
  assign transfer_buffer      = buf_reg;
  assign own_address_register = own_reg;
  assign port_interrupt_flag  = irq_reg;
  assign arb_lost             = lost_reg;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_byte_in;
    byte_end && match;
  endsequence

  sequence s_ninth_fall;
    state_reg == two_wire_pkg::ST_ACK && scl_fall && en && !stop_det &&
    !start_det;
  endsequence

  a_disable_idle: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    !ctl_reg[`CTL_EN_BIT] |-> scl_oe_n && sda_oe_n ##1
    state_reg == two_wire_pkg::ST_IDLE && !hold_reg && !ackd_reg)
    else $error("pins driven or slave busy while disabled");
  a_accept_ack: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    s_byte_in and (accept && en && !stop_det && !start_det && !ctrl_we) |=>
    bf_reg && !sda_oe_n && transfer_buffer == $past(shift_reg))
    else $error("accepted byte not acked or buffered");
  a_full_nack: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    s_byte_in and (bf_reg && en && !stop_det && !start_det && !buf_we) |=>
    !ackd_reg && ctl_reg[`CTL_OVF_BIT] && $stable(buf_reg))
    else $error("byte while full not refused");
  a_ninth_flag: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    s_ninth_fall |=> port_interrupt_flag && !ackd_reg)
    else $error("flag missing after ninth fall");
  a_send_stretch: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    $rose(state_reg == two_wire_pkg::ST_SEND) |->
    hold_reg && !scl_oe_n && !ctl_reg[`CTL_REL_BIT])
    else $error("no stretch entering transmit");
  a_stretch_line: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    $past(hold_reg, 2) && $past(ctl_reg[`CTL_EN_BIT], 2) |-> !scl_s)
    else $error("clock line not held low while stretching");
  a_nack_release: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    state_reg == two_wire_pkg::ST_SACK && scl_fall && !mack_reg &&
    en && !stop_det && !start_det && pin_direction_bits[1] |=>
    state_reg == two_wire_pkg::ST_IDLE && sda_oe_n)
    else $error("data not released after master nack");
  a_read_clears: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    buf_re && !byte_end |=> !bf_reg)
    else $error("buffer read did not clear full");
  a_start_flag: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    start_det && en && !stop_det |=> serial_port_status[3] &&
    !serial_port_status[4])
    else $error("start not flagged");
  a_arb_off: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    lost_reg && !slave_sda_low |-> sda_oe_n)
    else $error("firmware still drives after lost arbitration");
  a_fw_idle: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    en && ctl_reg[3:0] == `MODE_FW_MST && start_det |=>
    state_reg == two_wire_pkg::ST_IDLE [*2])
    else $error("slave left idle in firmware master mode");

endmodule : two_wire_slave_port

`default_nettype wire

/* File: inc/two_wire_map.svh */
// bit positions, mode codes and reset values of the two-wire slave port
// assumes: included by bare name wherever these constants are needed
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH

// control byte fields
`define CTL_OVF_BIT   6
`define CTL_EN_BIT    5
`define CTL_REL_BIT   4
`define CTL_MODE_HI   3
`define CTL_MODE_LO   0
`define CTL_RESET     8'h00

// status byte fields
`define STS_DATA_BIT  5
`define STS_STOP_BIT  4
`define STS_START_BIT 3
`define STS_READ_BIT  2
`define STS_UA_BIT    1
`define STS_BF_BIT    0

// mode select codes
`define MODE_SLV7     4'h6
`define MODE_SLV10    4'h7
`define MODE_SLV7_SP  4'he
`define MODE_SLV10_SP 4'hf
`define MODE_FW_MST   4'hb

// bits per byte on the wire
`define BYTE_LAST_BIT 4'h8
`define OWN_ADDR_RST  8'h00

`endif

/* File: inc/two_wire_pkg.sv */
// types shared by the two-wire slave port files
// assumes: compiled before any design file
package two_wire_pkg;

  // slave sequencer states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK  = 3'b010,
    ST_SEND = 3'b011,
    ST_SACK = 3'b100
  } slave_state_e;

  // which byte of the address is expected
  typedef enum logic [1:0]
  {
    PH_HIGH = 2'b00,
    PH_LOW  = 2'b01,
    PH_DATA = 2'b10
  } addr_phase_e;

endpackage : two_wire_pkg

/* File: verif/two_wire_master_model.sv */
// bus master model: open-drain clock and data, 80 ns bit period
// assumes: bench resolves wired-and lines with pull-ups
`timescale 1ns/10ps
`default_nettype none

module two_wire_master_model
(
  // resolved lines
  input  wire logic scl_line,
  input  wire logic sda_line,
  // drive, 0 pulls low; hang marks a clock held too long
  output logic      scl_m,
  output logic      sda_m,
  output logic      hang
);
  // ****************
  // bus sequencing
  // ****************
  // idle with both lines released
  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    hang = 1'b0;
  end

  // release clock, wait while a slave holds it low
  task automatic scl_up;
    int n;
    begin
      scl_m = 1'b1;
      n = 0;
      while (scl_line !== 1'b1 && n < 400)
      begin
        #10;
        n++;
      end
      hang = hang | (n >= 400);
    end
  endtask : scl_up

  // one bit: data set while clock low, sampled in the high phase
  task automatic put_bit(input logic b, output logic r);
    begin
      sda_m = b;
      #20;
      scl_up();
      #20;
      r = sda_line;
      #20;
      scl_m = 1'b0;
      #20;
    end
  endtask : put_bit

  // start, also used as repeated start after an acknowledge
  task automatic start_cond;
    begin
      sda_m = 1'b1;
      scl_up();
      #20;
      sda_m = 1'b0;
      #40;
      scl_m = 1'b0;
      #20;
    end
  endtask : start_cond

  // stop, data rises while clock high
  task automatic stop_cond;
    begin
      sda_m = 1'b0;
      #20;
      scl_up();
      #40;
      sda_m = 1'b1;
      #40;
    end
  endtask : stop_cond

  // eight bits msb first, then the acknowledge bit
  task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] q, output logic ackd);
    logic r;
    begin
      for (int i = 7; i >= 0; i--)
        put_bit(d[i], q[i]);
      put_bit(ack_in, r);
      ackd = ~r;
    end
  endtask : xfer_byte
endmodule : two_wire_master_model
`default_nettype wire

/* File: verif/two_wire_slave_port_tb.sv */
// self-checking bench of the two-wire slave port
// assumes: design and two_wire_master_model compiled before this file
`timescale 1ns/10ps
`default_nettype none

module two_wire_slave_port_tb;
  // ****************
  // dut and bus
  // ****************
  // row: control byte, address byte, expected ack and flag
  typedef struct packed
  {
    logic [7:0] ctrl;
    logic [7:0] abyte;
    logic       ack;
    logic       flag;
  } row_s;

  logic       ref_clk, nrst, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic       flag, scl_m, sda_m, hang, ack, arb;
  logic [1:0] pin_direction_bits;
  logic [4:0] stb;
  logic [7:0] wd, q, ctl, sts, buffer, own;
  int         error_cnt, n_tests;
  wire        scl_line = scl_m & (scl_oe_n ? 1'b1 : scl_out);
  wire        sda_line = sda_m & (sda_oe_n ? 1'b1 : sda_out);
  row_s       rows [5] = '{'{8'h36, 8'ha0, 1'b1, 1'b1},
    '{8'h36, 8'ha2, 1'b0, 1'b0}, '{8'h3e, 8'ha0, 1'b1, 1'b1},
    '{8'h3b, 8'ha0, 1'b0, 1'b1}, '{8'h16, 8'ha0, 1'b0, 1'b0}};

  two_wire_slave_port dut
  (
    .ref_clk, .nrst, .scl_in(scl_line), .scl_out, .scl_oe_n,
    .sda_in(sda_line), .sda_out, .sda_oe_n, .pin_direction_bits,
    .ctrl_we(stb[0]), .ctrl_wdata(wd), .serial_port_control(ctl),
    .serial_port_status(sts), .buf_we(stb[1]), .buf_wdata(wd),
    .buf_re(stb[2]), .transfer_buffer(buffer), .addr_we(stb[3]),
    .addr_wdata(wd), .own_address_register(own), .flag_clr(stb[4]),
    .port_interrupt_flag(flag), .arb_lost(arb)
  );

  two_wire_master_model m
  (
    .scl_line, .sda_line, .scl_m, .sda_m, .hang
  );

  // 100 MHz system clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  // ****************
  // helpers
  // ****************
  // compare and count
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    begin
      n_tests++;
      if (g !== e)
      begin
        $display("unexpected %s expected %h seen %h", nm, e, g);
        error_cnt++;
      end
    end
  endtask : chk

  // one strobe: 0 ctrl, 1 buf write, 2 buf read, 3 addr, 4 flag clear
  task automatic sw(input int k, input logic [7:0] v);
    begin
      @(negedge ref_clk);
      wd = v;
      stb = 5'h01 << k;
      @(negedge ref_clk);
      stb = 5'h00;
    end
  endtask : sw

  // counts and verdict
  task automatic end_sim;
    begin
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask : end_sim

  // a clock held past the model's bound ends the run
  always @(posedge hang)
  begin
    error_cnt++;
    end_sim();
  end

  // ****************
  // scenarios
  // ****************
  // reset, address table, then hand-written cases
  initial
  begin
    nrst = 1'b0;
    stb = 5'h00;
    wd = 8'h00;
    pin_direction_bits = 2'b11;
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    chk("reset control", 8'h00, ctl);
    chk("reset status", 8'h00, sts);
    chk("reset pins", 8'h03, {5'h0, flag, scl_oe_n, sda_oe_n});
    repeat (3) @(negedge ref_clk);
    sw(3, 8'ha0);
    chk("own address", 8'ha0, own);
    foreach (rows[i])
    begin
      sw(0, rows[i].ctrl);
      m.start_cond();
      m.xfer_byte(rows[i].abyte, 1'b1, q, ack);
      repeat (4) @(negedge ref_clk);
      chk("ack", {7'h0, rows[i].ack}, {7'h0, ack});
      chk("flag", {7'h0, rows[i].flag}, {7'h0, flag});
      if (rows[i].ack)
        chk("buffer", rows[i].abyte, buffer);
      m.stop_cond();
      sw(2, 8'h00);
      sw(4, 8'h00);
    end
    // firmware pulls the clock low
    sw(0, 8'h3b);
    pin_direction_bits = 2'b10;
    @(negedge ref_clk);
    chk("fw clock", 8'h00, {7'h0, scl_oe_n});
    pin_direction_bits = 2'b11;
    // byte while full: no ack, overflow, buffer kept
    sw(0, 8'h36);
    sw(4, 8'h00);
    m.start_cond();
    m.xfer_byte(8'ha0, 1'b1, q, ack);
    // let the ninth-fall flag land before clearing it
    repeat (4) @(negedge ref_clk);
    sw(4, 8'h00);
    m.xfer_byte(8'h11, 1'b1, q, ack);
    repeat (4) @(negedge ref_clk);
    chk("full ack", 8'h00, {7'h0, ack});
    chk("overflow", 8'h40, ctl & 8'h40);
    chk("kept", 8'ha0, buffer);
    chk("full flag", 8'h01, {7'h0, flag});
    chk("sda free", 8'h01, {7'h0, sda_oe_n});
    // firmware had the clock, released data, saw a low bit
    chk("arb lost", 8'h01, {7'h0, arb});
    m.stop_cond();
    sw(2, 8'h00);
    chk("full", 8'h00, sts & 8'h01);
    chk("ovf kept", 8'h40, ctl & 8'h40);
    chk("arb clear", 8'h00, {7'h0, arb});
    m.start_cond();
    m.xfer_byte(8'ha0, 1'b1, q, ack);
    chk("ovf ack", 8'h00, {7'h0, ack});
    m.stop_cond();
    sw(0, 8'h26);
    chk("ovf clear", 8'h00, ctl & 8'h40);
    // receive with release clear stretches the clock
    m.start_cond();
    m.xfer_byte(8'ha0, 1'b1, q, ack);
    repeat (5) @(negedge ref_clk);
    chk("rx stretch", 8'h00, {7'h0, scl_oe_n});
    sw(2, 8'h00);
    sw(0, 8'h36);
    chk("rx release", 8'h01, {7'h0, scl_oe_n});
    // repeated start into a read, master ends with no ack
    m.start_cond();
    m.xfer_byte(8'ha1, 1'b1, q, ack);
    repeat (5) @(negedge ref_clk);
    chk("read bit", 8'h04, sts & 8'h04);
    chk("tx stretch", 8'h00, {7'h0, scl_oe_n} | (ctl & 8'h10));
    sw(2, 8'h00);
    sw(1, 8'h5a);
    sw(0, 8'h36);
    m.xfer_byte(8'hff, 1'b1, q, ack);
    repeat (5) @(negedge ref_clk);
    chk("tx data", 8'h5a, q);
    chk("tx free", 8'h01, {7'h0, sda_oe_n});
    m.stop_cond();
    repeat (4) @(negedge ref_clk);
    chk("stop status", 8'h10, sts & 8'h14);
    // reset in mid-run returns control, status and address to zero
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    chk("reset again", 8'h00, ctl | sts | own);
    end_sim();
  end
endmodule : two_wire_slave_port_tb
`default_nettype wire
